// File: core/uhf_core.sv
// uhf_core: host side register port of a serial controller with 16-byte fifos.
// assumes host strobes are synchronous one-cycle pulses; serial side is plain ports.
`timescale 1ns/1ps
// Summary of operation
// - receive and transmit fifos, sixteen bytes each, between host and serial side
// - fifo enable bit makes both fifos active
// - dma mode select bit chooses dma servicing while fifos enabled
// - fifos disabled: one holding byte per direction, no queuing
// - receive buffer read returns oldest received character
// - transmit buffer write queues one character for sending
// - data ready flag set while receive fifo holds any character
// - identification code 4h while receive count at or above trigger
// - host interrupt follows receive count against trigger level, or the receive timeout
// - timeout code ch after four idle character times with data present
// - level and timeout interrupts only with fifos and receive enable on
module uhf_core #(
  parameter int unsigned CHAR_CYC = 200
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        fifo_cfg_wr_in,
  input  wire logic [7:0]  fifo_cfg_data_in,
  input  wire logic        rx_avail_int_enable_in,
  input  wire logic        rx_read_in,
  input  wire logic        write_strobe_in,
  input  wire logic [7:0]  tx_wr_data_in,
  input  wire logic [7:0]  ser_rx_data_in,
  input  wire logic        ser_rx_valid_in,
  input  wire logic        ser_tx_ready_in,
  output logic [7:0]       rx_data_out,
  output logic             rx_data_ready_flag_out,
  output logic [7:0]       interrupt_ident_out,
  output logic             host_interrupt_out,
  output logic             dma_mode_out,
  output logic             tx_full_out,
  output logic [7:0]       ser_tx_data_out,
  output logic             ser_tx_valid_out,
  output logic             ser_rx_ready_out
);
  localparam int unsigned TO_CYC = uhf_pkg::TIMEOUT_CHARS * CHAR_CYC;
  localparam int unsigned TO_W   = $clog2(TO_CYC + 1);

  logic [7:0]      fcfg_q, fcfg_d;
  logic            fifo_en;
  logic [4:0]      trig;
  logic [4:0]      rx_cnt, tx_cnt;
  logic [4:0]      rx_lim, tx_lim;
  logic [7:0]      rxf_data, txf_data;
  logic            rxf_valid, rxf_wready, txf_valid, txf_wready;
  logic            rx_pop, tx_push, rx_push, flush;
  logic [TO_W-1:0] to_q, to_d;
  logic            to_flag_q, to_flag_d;
  logic [7:0]      rdat_q, rdat_d, iid_q, iid_d, txd_q, txd_d;
  logic            rdy_q, rdy_d, int_q, int_d, dma_q, dma_d, full_q, full_d;
  logic            txv_q, txv_d, rxr_q, rxr_d;
  logic            lvl_hit, int_on;
  logic [3:0]      iid_code;

  assign fifo_en = fcfg_q[uhf_pkg::FCFG_FIFO_EN];
  // without fifos each direction holds a single byte, as the older part did
  assign rx_lim  = fifo_en ? 5'(uhf_pkg::FIFO_DEPTH) : 5'h01;
  assign tx_lim  = rx_lim;
  assign rx_push = ser_rx_valid_in && rxr_q && rxf_wready;
  assign rx_pop  = rx_read_in && rxf_valid;
  assign tx_push = write_strobe_in && (tx_cnt < tx_lim) && txf_wready;
  // toggling fifo enable empties both fifos; a byte already in the tx holding register is still offered and sent
  assign flush   = fifo_cfg_wr_in && (fifo_cfg_data_in[uhf_pkg::FCFG_FIFO_EN] != fifo_en);

  always_comb
  begin
    case (fcfg_q[uhf_pkg::FCFG_TRIG_HI:uhf_pkg::FCFG_TRIG_LO])
      2'b00:   trig = uhf_pkg::TRIG_00;
      2'b01:   trig = uhf_pkg::TRIG_01;
      2'b10:   trig = uhf_pkg::TRIG_10;
      2'b11:   trig = uhf_pkg::TRIG_11;
      default: trig = uhf_pkg::TRIG_00;
    endcase
  end

  uhf_fifo #(.WIDTH(uhf_pkg::DATA_W), .DEPTH(uhf_pkg::FIFO_DEPTH)) u_rx_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .flush_in     (flush),
    .wr_data_in   (ser_rx_data_in),
    .wr_valid_in  (rx_push),
    .wr_ready_out (rxf_wready),
    .rd_data_out  (rxf_data),
    .rd_valid_out (rxf_valid),
    .rd_ready_in  (rx_read_in),
    .count_out    (rx_cnt)
  );

  uhf_fifo #(.WIDTH(uhf_pkg::DATA_W), .DEPTH(uhf_pkg::FIFO_DEPTH)) u_tx_fifo (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .flush_in     (flush),
    .wr_data_in   (tx_wr_data_in),
    .wr_valid_in  (tx_push),
    .wr_ready_out (txf_wready),
    .rd_data_out  (txf_data),
    .rd_valid_out (txf_valid),
    .rd_ready_in  (ser_tx_ready_in && txv_q),
    .count_out    (tx_cnt)
  );

  assign int_on  = fifo_en && rx_avail_int_enable_in;
  // a flush empties the fifo this cycle, so its old count must not raise the level
  assign lvl_hit = int_on && !flush && (rx_cnt >= trig);

  always_comb
  begin
    fcfg_d = fifo_cfg_wr_in ? fifo_cfg_data_in : fcfg_q;
    // timer restarts on each arrival or host read, runs only while data waits
    if (flush || rx_push || rx_pop || !rxf_valid)
      to_d = '0;
    else if (to_q != TO_W'(TO_CYC))
      to_d = to_q + TO_W'(1);
    else
      to_d = to_q;
    to_flag_d = int_on && rxf_valid && (to_d == TO_W'(TO_CYC));
    if (lvl_hit)
      iid_code = uhf_pkg::IID_RX_AVAIL;
    else if (to_flag_d)
      iid_code = uhf_pkg::IID_TIMEOUT;
    else
      iid_code = uhf_pkg::IID_NONE;
    iid_d  = {{2{fcfg_d[uhf_pkg::FCFG_FIFO_EN]}}, 2'b00, iid_code};
    int_d  = lvl_hit || to_flag_d;
    rdy_d  = (rx_cnt + 5'(rx_push) - 5'(rx_pop)) != 5'h00;
    rdat_d = rx_pop ? rxf_data : rdat_q;
    dma_d  = fcfg_d[uhf_pkg::FCFG_FIFO_EN] && fcfg_d[uhf_pkg::FCFG_DMA_SEL];
    full_d = (tx_cnt + 5'(tx_push)) >= tx_lim;
    rxr_d  = (rx_cnt + 5'(rx_push)) < rx_lim;
    // a fifo enable change empties both fifos, so the data ready, tx full and rx ready flags restart; the tx holding register keeps its byte
    if (flush)
    begin
      rdy_d  = 1'b0;
      full_d = 1'b0;
      rxr_d  = 1'b1;
    end
    txv_d  = txv_q;
    txd_d  = txd_q;
    if (txv_q && ser_tx_ready_in)
      txv_d = 1'b0;
    else if (!txv_q && txf_valid)
    begin
      txv_d = 1'b1;
      txd_d = txf_data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fcfg_q    <= uhf_pkg::FCFG_RESET;
      to_q      <= '0;
      to_flag_q <= 1'b0;
      rdat_q    <= 8'h00;
      iid_q     <= {4'h0, uhf_pkg::IID_NONE};
      int_q     <= 1'b0;
      rdy_q     <= 1'b0;
      dma_q     <= 1'b0;
      full_q    <= 1'b0;
      rxr_q     <= 1'b0;
      txv_q     <= 1'b0;
      txd_q     <= 8'h00;
    end
    else
    begin
      fcfg_q    <= fcfg_d;
      to_q      <= to_d;
      to_flag_q <= to_flag_d;
      rdat_q    <= rdat_d;
      iid_q     <= iid_d;
      int_q     <= int_d;
      rdy_q     <= rdy_d;
      dma_q     <= dma_d;
      full_q    <= full_d;
      rxr_q     <= rxr_d;
      txv_q     <= txv_d;
      txd_q     <= txd_d;
    end
  end

  // the holding register mirrors the tx fifo head; the head is popped only when the serial side takes it
  assign rx_data_out            = rdat_q;
  assign rx_data_ready_flag_out = rdy_q;
  assign interrupt_ident_out    = iid_q;
  assign host_interrupt_out     = int_q;
  assign dma_mode_out           = dma_q;
  assign tx_full_out            = full_q;
  assign ser_tx_data_out        = txd_q;
  assign ser_tx_valid_out       = txv_q;
  assign ser_rx_ready_out       = rxr_q;

  property p_rdy_tracks;
    @(posedge clk_in) disable iff (!rst_n_in) ##1 !$past(flush) |-> rdy_q == (rx_cnt != 5'h00);
  endproperty
  a_rdy_tracks: assert property (p_rdy_tracks) else $error("data ready flag wrong");
  property p_level_int;
    @(posedge clk_in) disable iff (!rst_n_in) lvl_hit |=> int_q && iid_q[3:0] == uhf_pkg::IID_RX_AVAIL;
  endproperty
  a_level_int: assert property (p_level_int) else $error("level interrupt missing");
  property p_below_clear;
    @(posedge clk_in) disable iff (!rst_n_in) (rx_cnt < trig) && !to_flag_d |=> iid_q[3:0] != uhf_pkg::IID_RX_AVAIL;
  endproperty
  a_below_clear: assert property (p_below_clear) else $error("level code stuck");
  property p_gate;
    @(posedge clk_in) disable iff (!rst_n_in) !int_on |=> !int_q;
  endproperty
  a_gate: assert property (p_gate) else $error("interrupt without enable");
  property p_timeout;
    @(posedge clk_in) disable iff (!rst_n_in) to_flag_q |-> int_q && rxf_valid;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout without data");
  property p_read_clr;
    @(posedge clk_in) disable iff (!rst_n_in) rx_pop |=> !to_flag_q;
  endproperty
  a_read_clr: assert property (p_read_clr) else $error("read did not clear timeout");
  property p_single;
    @(posedge clk_in) disable iff (!rst_n_in) !fifo_en |-> rx_cnt <= 5'h01 && tx_cnt <= 5'h01;
  endproperty
  a_single: assert property (p_single) else $error("queued while fifos off");
  property p_read_data;
    @(posedge clk_in) disable iff (!rst_n_in) rx_pop |=> rdat_q == $past(rxf_data);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");
  property p_dma;
    @(posedge clk_in) disable iff (!rst_n_in) dma_q |-> fifo_en;
  endproperty
  a_dma: assert property (p_dma) else $error("dma without fifos");
  c_timeout: cover property (@(posedge clk_in) to_flag_q);
  c_full:    cover property (@(posedge clk_in) rx_cnt == 5'h10);
  c_trig14:  cover property (@(posedge clk_in) lvl_hit && trig == uhf_pkg::TRIG_11);
endmodule : uhf_core

// File: core/uhf_pkg.sv
// uhf_pkg: constants shared by the host fifo port core and its fifo.
// assumes a single 20 MHz clock domain.
package uhf_pkg;
  localparam int unsigned FIFO_DEPTH      = 16;
  localparam int unsigned DATA_W          = 8;
  localparam int unsigned CNT_W           = 5;
  // fifo_config_reg field positions
  localparam int unsigned FCFG_FIFO_EN    = 0;
  localparam int unsigned FCFG_DMA_SEL    = 3;
  localparam int unsigned FCFG_TRIG_LO    = 6;
  localparam int unsigned FCFG_TRIG_HI    = 7;
  // receive trigger thresholds
  localparam logic [4:0]  TRIG_00         = 5'h01;
  localparam logic [4:0]  TRIG_01         = 5'h04;
  localparam logic [4:0]  TRIG_10         = 5'h08;
  localparam logic [4:0]  TRIG_11         = 5'h0e;
  // interrupt identification codes
  localparam logic [3:0]  IID_NONE        = 4'h1;
  localparam logic [3:0]  IID_RX_AVAIL    = 4'h4;
  localparam logic [3:0]  IID_TIMEOUT     = 4'hc;
  localparam int unsigned TIMEOUT_CHARS   = 4;
  localparam logic [7:0]  FCFG_RESET      = 8'h00;
  // host strobe spacing: two internal cpu periods plus 15 ns
  localparam real         CPU_CLK_MHZ     = 28.224;
  localparam real         STROBE_EXTRA_NS = 15.0;
  localparam real         CLK_PERIOD_NS   = 50.0;
  localparam int unsigned STROBE_GAP_CYC  = int'($ceil((2.0 * 1000.0 / CPU_CLK_MHZ + STROBE_EXTRA_NS)
                                                        / CLK_PERIOD_NS));
endpackage : uhf_pkg

// File: core/uhf_fifo.sv
// uhf_fifo: synchronous fifo with valid/ready on both sides.
// assumes single clock, asynchronous active low reset.
`timescale 1ns/1ps
module uhf_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     flush_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  input  wire logic                     wr_valid_in,
  output logic                          wr_ready_out,
  output logic [WIDTH-1:0]              rd_data_out,
  output logic                          rd_valid_out,
  input  wire logic                     rd_ready_in,
  output logic [$clog2(DEPTH):0]        count_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out  = mem_q[rp_q];
  assign count_out    = cnt_q;
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = rd_valid_out && rd_ready_in;

  always_comb
  begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (flush_in)
    begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
    else
    begin
      if (push)
        wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
      if (pop)
        rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; only pointers and count need a defined value
  always_ff @(posedge clk_in)
  begin
    if (push && !flush_in)
      mem_q[wp_q] <= wr_data_in;
  end

  property p_no_overfill;
    @(posedge clk_in) disable iff (!rst_n_in) cnt_q <= (AW+1)'(DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("fifo count above depth");
endmodule : uhf_fifo

// File: test/uhf_serial_model.sv
// uhf_serial_model: serial side of the core, feeds rx chars and drains tx chars.
// assumes the bench calls send() and drives stall_in at falling edges.
`timescale 1ns/1ps
module uhf_serial_model (
  input  wire logic       clk_in,
  input  wire logic       stall_in,
  input  wire logic       rx_ready_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  output logic            tx_ready_out
);
  int slow;
  initial
  begin
    rx_data_out  = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
    slow         = 0;
  end
  // ready is high two cycles in four, so the core must hold its offer
  always @(negedge clk_in)
  begin
    slow         = slow + 1;
    tx_ready_out = !stall_in && slow[1];
  end
  task automatic send(input logic [7:0] b);
    @(negedge clk_in);
    rx_data_out  = b;
    rx_valid_out = 1'b1;
    // ready only moves on a rising edge, so its value here is what the next rising edge sees
    while (!rx_ready_in) @(negedge clk_in);
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    rx_data_out  = ~b; // released data never repeats the last byte
  endtask : send
endmodule : uhf_serial_model

// File: test/uhf_core_bench.sv
// uhf_core_bench: self-checking bench for the host fifo port core.
// assumes uhf_core, uhf_fifo and uhf_serial_model are compiled first.
`timescale 1ns/1ps
module uhf_core_bench;
  logic       clk = 0, rst_n = 0, cfg_wr = 0, int_en = 0, rd = 0, wr = 0, stall = 1;
  logic [7:0] cfg_d = 8'h00, wr_d = 8'h00, rx_d, ident, tx_d, sd, rx_sd;
  logic       rx_v, tx_r, flag, irq, dma, full, tx_v, rx_r, rd_s1 = 0, rd_s2 = 0;
  logic [7:0] mdl[$], rxq[$], txq[$];
  logic [7:0] lv[4] = '{8'h01, 8'h04, 8'h08, 8'h0e};
  int         failures = 0, n_compared = 0, seed = 7946, n;
  always #25 clk = ~clk;
  uhf_core #(.CHAR_CYC(5)) dut (.clk_in(clk), .rst_n_in(rst_n), .fifo_cfg_wr_in(cfg_wr),
    .fifo_cfg_data_in(cfg_d), .rx_avail_int_enable_in(int_en), .rx_read_in(rd),
    .write_strobe_in(wr), .tx_wr_data_in(wr_d), .ser_rx_data_in(rx_sd), .ser_rx_valid_in(rx_v),
    .ser_tx_ready_in(tx_r), .rx_data_out(rx_d), .rx_data_ready_flag_out(flag),
    .interrupt_ident_out(ident), .host_interrupt_out(irq), .dma_mode_out(dma),
    .tx_full_out(full), .ser_tx_data_out(tx_d), .ser_tx_valid_out(tx_v), .ser_rx_ready_out(rx_r));
  uhf_serial_model sm (.clk_in(clk), .stall_in(stall), .rx_ready_in(rx_r), .rx_data_out(rx_sd),
    .rx_valid_out(rx_v), .tx_ready_out(tx_r));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  // sel: 0 config write, 1 receive read, 2 transmit write
  task automatic pulse(input int sel);
    @(negedge clk);
    cfg_wr = (sel == 0);
    rd     = (sel == 1);
    wr     = (sel == 2);
    @(negedge clk);
    cfg_wr = 1'b0;
    rd     = 1'b0;
    wr     = 1'b0;
    repeat (uhf_pkg::STROBE_GAP_CYC - 1) @(negedge clk); // host strobe spacing
  endtask : pulse
  task automatic cfg(input logic [7:0] v);
    cfg_d = v;
    pulse(0);
  endtask : cfg
  task automatic put();
    sd = 8'($random(seed));
    mdl.push_back(sd);
    sm.send(sd);
  endtask : put
  task automatic rdx();
    rxq.push_back(mdl.pop_front());
    pulse(1);
  endtask : rdx
  task automatic st(input logic [7:0] id, input logic f, input logic i);
    repeat (3) @(negedge clk);
    check("ident", ident, id);
    check("ready_flag", {7'h00, flag}, {7'h00, f});
    check("interrupt", {7'h00, irq}, {7'h00, i});
  endtask : st
  // read data is looked at two cycles on, where it stands whatever the latency
  always @(posedge clk)
  begin
    rd_s1 <= rd;
    rd_s2 <= rd_s1;
  end
  always @(negedge clk)
    if (rd_s2 && rxq.size() > 0)
      check("rx_data", rx_d, rxq.pop_front());
  always @(posedge clk)
    if (tx_v && tx_r)
      check("tx_data", tx_d, (txq.size() > 0) ? txq.pop_front() : ~tx_d);
  initial
  begin
    #(50 * 20000);
    failures++;
    conclude();
  end
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    st(8'h01, 1'b0, 1'b0);
    int_en = 1'b1;
    foreach (lv[k])
    begin
      cfg({k[1:0], 2'b00, k[0], 3'b001});
      check("dma", {7'h00, dma}, {7'h00, k[0]});
      repeat (lv[k] - 1) put();
      st(8'hc1, lv[k] > 1, 1'b0);
      put();
      st(8'hc4, 1'b1, 1'b1);
      rdx();
      st(8'hc1, lv[k] > 1, 1'b0);
      while (mdl.size() > 0) rdx();
    end
    cfg(8'hc1);
    repeat (16) put();
    repeat (2) @(negedge clk);
    check("rx_ready_full", {7'h00, rx_r}, 8'h00);
    repeat (16) rdx();
    st(8'hc1, 1'b0, 1'b0);
    put();
    put();
    repeat (10) @(negedge clk);
    check("ident_early", ident, 8'hc1);
    repeat (20) @(negedge clk);
    check("ident_timeout", ident, 8'hcc);
    rdx();
    st(8'hc1, 1'b1, 1'b0);
    repeat (30) @(negedge clk);
    check("ident_timeout2", ident, 8'hcc);
    rdx();
    int_en = 1'b0;
    cfg(8'h01);
    put();
    repeat (30) @(negedge clk);
    st(8'hc1, 1'b1, 1'b0);
    rdx();
    int_en = 1'b1;
    cfg(8'h08);
    check("dma_off", {7'h00, dma}, 8'h00);
    put();
    st(8'h01, 1'b1, 1'b0);
    check("rx_ready_off", {7'h00, rx_r}, 8'h00);
    rdx();
    st(8'h01, 1'b0, 1'b0);
    cfg(8'h01);
    n = 0;
    while (!full && n < 24)
    begin
      wr_d = 8'($random(seed));
      txq.push_back(wr_d);
      pulse(2);
      n++;
    end
    check("tx_depth", 8'(n), 8'h10);
    check("tx_full", {7'h00, full}, 8'h01);
    wr_d = 8'($random(seed));
    pulse(2);
    stall = 1'b0;
    repeat (150) @(negedge clk);
    check("tx_left", 8'(txq.size()), 8'h00);
    check("tx_full_drained", {7'h00, full}, 8'h00);
    conclude();
  end
endmodule : uhf_core_bench
